// ### inc/ecr_regs.svh
// constants of the two-wire serial memory client and its host
`ifndef ECR_REGS_SVH
`define ECR_REGS_SVH
`define ECR_CTRL_CODE 4'ha
`define ECR_DIR_RD 1'h1
`define ECR_DIR_WR 1'h0
`define ECR_ADDR_W 10
`define ECR_PTR_STEP 10'h001
`define ECR_BIT_LAST 4'h8
`define ECR_BIT_STEP 4'h1
`define ECR_PROG_CYCLES 1024
`define ECR_QTR_CYCLES 16
`define ECR_STEP_CTRL 2'h0
`define ECR_STEP_ADDR 2'h1
`define ECR_STEP_DATA 2'h2
`define ECR_STEP_CTRL_RD 2'h3
`define ECR_STEP_INC 2'h1
`define ECR_LEN_ONE 8'h01
`define ECR_LEN_TWO 8'h02
`endif

// ### inc/ecr_pkg.sv
// types shared by the memory client and its bus host
package ecr_pkg;
    typedef enum logic [4:0] {
        ECR_S_IDLE = 5'h01,
        ECR_S_RECV = 5'h02,
        ECR_S_ACK = 5'h04,
        ECR_S_SEND = 5'h08,
        ECR_S_HACK = 5'h10
    } ecr_dev_state_t;
    typedef enum logic [3:0] {
        ECR_P_CTRL = 4'h1,
        ECR_P_ADDR = 4'h2,
        ECR_P_DATA = 4'h4,
        ECR_P_READ = 4'h8
    } ecr_phase_t;
    typedef enum logic [3:0] {
        ECR_H_IDLE = 4'h1,
        ECR_H_START = 4'h2,
        ECR_H_XFER = 4'h4,
        ECR_H_STOP = 4'h8
    } ecr_host_state_t;
    typedef enum logic [1:0] {
        ECR_OP_WRITE = 2'h0,
        ECR_OP_CUR = 2'h1,
        ECR_OP_RAND = 2'h2,
        ECR_OP_POLL = 2'h3
    } ecr_op_t;
endpackage : ecr_pkg

// ### inc/ecr_if.sv
// two-wire bus between host and memory client, with open-drain data line
interface ecr_if;
    logic scl;
    logic sda;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    // wired-and of both drivers with a pull-up
    assign sda = !((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o));
    modport host (
        output scl,
        output host_sda_o,
        output host_sda_oe_n,
        input sda
    );
    modport dev (
        input scl,
        input sda,
        output dev_sda_o,
        output dev_sda_oe_n
    );
endinterface : ecr_if

// ### hdl/ecr_client.sv
// memory client end: control byte decode, address pointer, reads, busy polling
// Functional notes
// - no acknowledge while programming cycle runs
// - programming starts at stop ending write
// - host polls with write control byte
// - acknowledge poll once programming has finished
// - direction one selects a read kind
// - pointer holds last accessed location plus one
// - acknowledge read, send byte msb first
// - host nacks and stops; client stops driving
// - dummy write loads pointer, restart abandons write
// - host resends control byte for reading
// - host acknowledge continues with next byte
// - pointer increments with every data byte read or written
// - control byte code, ignored bit, block, direction
// - address from block bits plus word byte
// - released data line after host nack
`include "ecr_regs.svh"
module ecr_client #(
    parameter int unsigned PROG_CYCLES = `ECR_PROG_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    ecr_if.dev bus,
    output logic busy,
    output logic [`ECR_ADDR_W-1:0] pointer
);
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    ecr_pkg::ecr_dev_state_t state_r;
    ecr_pkg::ecr_phase_t phase_r;
    logic [3:0] cnt_r;
    logic [7:0] rx_r;
    logic [7:0] tx_r;
    logic [1:0] blk_r;
    logic [`ECR_ADDR_W-1:0] ptr_r;
    logic pend_r;
    logic hack_r;
    logic oe_n_r;
    logic [31:0] busy_cnt_r;
    logic byte_done;
    logic ctrl_ok;
    logic load_rd;
    logic [7:0] rd_byte;
    logic [7:0] mem [0:(1 << `ECR_ADDR_W) - 1];

    assign scl_rise = bus.scl && !scl_q;
    assign scl_fall = !bus.scl && scl_q;
    // data moving while the clock stays high marks start and stop
    assign start_ev = bus.scl && scl_q && sda_q && !bus.sda;
    assign stop_ev = bus.scl && scl_q && !sda_q && bus.sda;
    assign byte_done = (state_r == ecr_pkg::ECR_S_RECV) && scl_fall && (cnt_r == `ECR_BIT_LAST);
    assign ctrl_ok = (rx_r[7:4] == `ECR_CTRL_CODE) && !busy;
    assign load_rd = scl_fall && (((state_r == ecr_pkg::ECR_S_ACK)
                     && (phase_r == ecr_pkg::ECR_P_READ))
                     || ((state_r == ecr_pkg::ECR_S_HACK) && hack_r));
    assign rd_byte = mem[ptr_r];
    assign busy = (busy_cnt_r != 32'h0000_0000);
    assign pointer = ptr_r;
    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe_n = oe_n_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= bus.scl;
            sda_q <= bus.sda;
        end
    end

    // bus protocol sequencer and data line driver
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= ecr_pkg::ECR_S_IDLE;
            phase_r <= ecr_pkg::ECR_P_CTRL;
            cnt_r <= 4'h0;
            rx_r <= 8'h00;
            blk_r <= 2'h0;
            pend_r <= 1'b0;
            hack_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else if (start_ev) begin
            // a repeated start cancels any pending programming cycle
            state_r <= ecr_pkg::ECR_S_RECV;
            phase_r <= ecr_pkg::ECR_P_CTRL;
            cnt_r <= 4'h0;
            pend_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else if (stop_ev) begin
            state_r <= ecr_pkg::ECR_S_IDLE;
            pend_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else begin
            case (state_r)
                ecr_pkg::ECR_S_RECV: begin
                    if (scl_rise) begin
                        rx_r <= {rx_r[6:0], bus.sda};
                        cnt_r <= cnt_r + `ECR_BIT_STEP;
                    end else if (byte_done) begin
                        state_r <= ecr_pkg::ECR_S_ACK;
                        oe_n_r <= 1'b0;
                        case (phase_r)
                            ecr_pkg::ECR_P_CTRL: begin
                                blk_r <= rx_r[2:1];
                                if (!ctrl_ok) begin
                                    state_r <= ecr_pkg::ECR_S_IDLE;
                                    oe_n_r <= 1'b1;
                                end else if (rx_r[0] == `ECR_DIR_RD) begin
                                    phase_r <= ecr_pkg::ECR_P_READ;
                                end else begin
                                    phase_r <= ecr_pkg::ECR_P_ADDR;
                                end
                            end
                            ecr_pkg::ECR_P_ADDR: begin
                                phase_r <= ecr_pkg::ECR_P_DATA;
                                pend_r <= 1'b1;
                            end
                            default: begin
                                phase_r <= ecr_pkg::ECR_P_DATA;
                                pend_r <= 1'b1;
                            end
                        endcase
                    end
                end
                ecr_pkg::ECR_S_ACK: begin
                    if (scl_fall) begin
                        cnt_r <= 4'h0;
                        if (phase_r == ecr_pkg::ECR_P_READ) begin
                            state_r <= ecr_pkg::ECR_S_SEND;
                            oe_n_r <= rd_byte[7];
                        end else begin
                            state_r <= ecr_pkg::ECR_S_RECV;
                            oe_n_r <= 1'b1;
                        end
                    end
                end
                ecr_pkg::ECR_S_SEND: begin
                    if (scl_rise) begin
                        cnt_r <= cnt_r + `ECR_BIT_STEP;
                    end else if (scl_fall) begin
                        if (cnt_r == `ECR_BIT_LAST) begin
                            state_r <= ecr_pkg::ECR_S_HACK;
                            oe_n_r <= 1'b1;
                        end else begin
                            oe_n_r <= tx_r[6];
                        end
                    end
                end
                ecr_pkg::ECR_S_HACK: begin
                    if (scl_rise) begin
                        hack_r <= !bus.sda;
                    end else if (load_rd) begin
                        state_r <= ecr_pkg::ECR_S_SEND;
                        cnt_r <= 4'h0;
                        oe_n_r <= rd_byte[7];
                    end else if (scl_fall) begin
                        // no acknowledge: keep the line free for the stop
                        state_r <= ecr_pkg::ECR_S_IDLE;
                        oe_n_r <= 1'b1;
                    end
                end
                ecr_pkg::ECR_S_IDLE: begin
                    oe_n_r <= 1'b1;
                end
                default: begin
                    state_r <= ecr_pkg::ECR_S_IDLE;
                    oe_n_r <= 1'b1;
                end
            endcase
        end
    end

    // outgoing byte shifter
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_r <= 8'h00;
        end else if (load_rd) begin
            tx_r <= rd_byte;
        end else if ((state_r == ecr_pkg::ECR_S_SEND) && scl_fall) begin
            tx_r <= {tx_r[6:0], 1'b1};
        end
    end

    // address pointer: set by the word address, stepped after every data byte read or written
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ptr_r <= '0;
        end else if (byte_done && (phase_r == ecr_pkg::ECR_P_ADDR)) begin
            ptr_r <= {blk_r, rx_r};
        end else if ((byte_done && (phase_r == ecr_pkg::ECR_P_DATA)) || load_rd) begin
            ptr_r <= ptr_r + `ECR_PTR_STEP;
        end
    end

    // written bytes go straight to the array
    always_ff @(posedge core_clk) begin
        if (byte_done && (phase_r == ecr_pkg::ECR_P_DATA)) begin
            mem[ptr_r] <= rx_r;
        end
    end

    // internally timed programming cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy_cnt_r <= 32'h0000_0000;
        end else if (stop_ev && pend_r) begin
            busy_cnt_r <= PROG_CYCLES;
        end else if (busy) begin
            busy_cnt_r <= busy_cnt_r - 32'h0000_0001;
        end
    end
endmodule : ecr_client

// ### hdl/ecr_host.sv
// bus host end: drives the clock, frames write, read and polling commands
`include "ecr_regs.svh"
module ecr_host #(
    parameter int unsigned QTR_CYCLES = `ECR_QTR_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    ecr_if.host bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire ecr_pkg::ecr_op_t cmd_op,
    input wire logic [`ECR_ADDR_W-1:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic [7:0] cmd_rd_len,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic done,
    output logic done_nack
);
    ecr_pkg::ecr_host_state_t state_r;
    ecr_pkg::ecr_op_t op_r;
    logic [15:0] qcnt_r;
    logic tick;
    logic [1:0] q_r;
    logic [3:0] bit_r;
    logic [8:0] sh_r;
    logic [8:0] rx_r;
    logic [`ECR_ADDR_W-1:0] addr_r;
    logic [7:0] wdata_r;
    logic [7:0] left_r;
    logic [1:0] step_r;
    logic rd_mode_r;
    logic scl_r;
    logic oe_n_r;

    function automatic logic [7:0] tx_byte(input logic [1:0] step, input ecr_pkg::ecr_op_t op,
                                           input logic [`ECR_ADDR_W-1:0] addr,
                                           input logic [7:0] wdata);
        logic dir;
        dir = (op == ecr_pkg::ECR_OP_CUR) ? `ECR_DIR_RD : `ECR_DIR_WR;
        case (step)
            `ECR_STEP_CTRL: tx_byte = {`ECR_CTRL_CODE, 1'b0, addr[9:8], dir};
            `ECR_STEP_ADDR: tx_byte = addr[7:0];
            `ECR_STEP_DATA: tx_byte = wdata;
            default: tx_byte = {`ECR_CTRL_CODE, 1'b0, addr[9:8], `ECR_DIR_RD};
        endcase
    endfunction : tx_byte

    assign tick = (qcnt_r == 16'(QTR_CYCLES - 1));
    assign cmd_ready = (state_r == ecr_pkg::ECR_H_IDLE);
    assign bus.scl = scl_r;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_sda_oe_n = oe_n_r;

    // quarter-bit enable divider
    always_ff @(posedge core_clk) begin
        if (rst || (state_r == ecr_pkg::ECR_H_IDLE) || tick) begin
            qcnt_r <= 16'h0000;
        end else begin
            qcnt_r <= qcnt_r + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= ecr_pkg::ECR_H_IDLE;
            op_r <= ecr_pkg::ECR_OP_WRITE;
            q_r <= 2'h0;
            bit_r <= 4'h0;
            sh_r <= 9'h1ff;
            rx_r <= 9'h000;
            addr_r <= '0;
            wdata_r <= 8'h00;
            left_r <= 8'h00;
            step_r <= `ECR_STEP_CTRL;
            rd_mode_r <= 1'b0;
            scl_r <= 1'b1;
            oe_n_r <= 1'b1;
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
            done <= 1'b0;
            done_nack <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            done <= 1'b0;
            if (tick) begin
                q_r <= q_r + 2'h1;
            end
            case (state_r)
                ecr_pkg::ECR_H_IDLE: begin
                    q_r <= 2'h0;
                    if (cmd_valid) begin
                        op_r <= cmd_op;
                        addr_r <= cmd_addr;
                        wdata_r <= cmd_wdata;
                        left_r <= (cmd_rd_len == 8'h00) ? `ECR_LEN_ONE : cmd_rd_len;
                        step_r <= `ECR_STEP_CTRL;
                        rd_mode_r <= 1'b0;
                        done_nack <= 1'b0;
                        state_r <= ecr_pkg::ECR_H_START;
                    end
                end
                ecr_pkg::ECR_H_START: begin
                    if (tick) begin
                        case (q_r)
                            2'h0: oe_n_r <= 1'b1;
                            2'h1: scl_r <= 1'b1;
                            2'h2: oe_n_r <= 1'b0;
                            default: begin
                                scl_r <= 1'b0;
                                sh_r <= {tx_byte(step_r, op_r, addr_r, wdata_r), 1'b1};
                                bit_r <= 4'h0;
                                state_r <= ecr_pkg::ECR_H_XFER;
                            end
                        endcase
                    end
                end
                ecr_pkg::ECR_H_XFER: begin
                    if (tick) begin
                        case (q_r)
                            2'h0: oe_n_r <= sh_r[8];
                            2'h1: scl_r <= 1'b1;
                            2'h2: rx_r <= {rx_r[7:0], bus.sda};
                            default: begin
                                scl_r <= 1'b0;
                                sh_r <= {sh_r[7:0], 1'b1};
                                bit_r <= bit_r + `ECR_BIT_STEP;
                                if (bit_r == `ECR_BIT_LAST) begin
                                    bit_r <= 4'h0;
                                    if (rd_mode_r) begin
                                        rd_valid <= 1'b1;
                                        rd_data <= rx_r[8:1];
                                        if (left_r > `ECR_LEN_ONE) begin
                                            left_r <= left_r - `ECR_LEN_ONE;
                                            sh_r <= {8'hff, left_r == `ECR_LEN_TWO};
                                        end else begin
                                            state_r <= ecr_pkg::ECR_H_STOP;
                                        end
                                    end else if (rx_r[0]) begin
                                        done_nack <= 1'b1;
                                        state_r <= ecr_pkg::ECR_H_STOP;
                                    end else if ((op_r == ecr_pkg::ECR_OP_POLL)
                                                 || ((op_r == ecr_pkg::ECR_OP_WRITE)
                                                 && (step_r == `ECR_STEP_DATA))) begin
                                        state_r <= ecr_pkg::ECR_H_STOP;
                                    end else if (((op_r == ecr_pkg::ECR_OP_CUR)
                                                 && (step_r == `ECR_STEP_CTRL))
                                                 || (step_r == `ECR_STEP_CTRL_RD)) begin
                                        rd_mode_r <= 1'b1;
                                        sh_r <= {8'hff, left_r == `ECR_LEN_ONE};
                                    end else if ((op_r == ecr_pkg::ECR_OP_RAND)
                                                 && (step_r == `ECR_STEP_ADDR)) begin
                                        step_r <= `ECR_STEP_CTRL_RD;
                                        state_r <= ecr_pkg::ECR_H_START;
                                    end else begin
                                        step_r <= step_r + `ECR_STEP_INC;
                                        sh_r <= {tx_byte(step_r + `ECR_STEP_INC, op_r, addr_r,
                                                         wdata_r), 1'b1};
                                    end
                                end
                            end
                        endcase
                    end
                end
                ecr_pkg::ECR_H_STOP: begin
                    if (tick) begin
                        case (q_r)
                            2'h0: oe_n_r <= 1'b0;
                            2'h1: scl_r <= 1'b1;
                            2'h2: oe_n_r <= 1'b1;
                            default: begin
                                done <= 1'b1;
                                state_r <= ecr_pkg::ECR_H_IDLE;
                            end
                        endcase
                    end
                end
                default: state_r <= ecr_pkg::ECR_H_IDLE;
            endcase
        end
    end
endmodule : ecr_host

// ### sim/ecr_chk.sv
// concurrent checks on the two-wire bus between host and memory client
module ecr_chk #(
    parameter int unsigned PROG_CYCLES = 1024
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe_n,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned busy_cnt_r;

    // length of the current programming interval
    always_ff @(posedge core_clk) begin
        if (rst || !busy) begin
            busy_cnt_r <= 0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_start;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence s_stop;
        scl && $past(scl) && $rose(sda);
    endsequence
    sequence s_quiet8;
        dev_sda_oe_n [*8];
    endsequence

    property p_dev_stable_high;
        scl && $past(scl) |-> $stable(dev_sda_oe_n);
    endproperty
    property p_busy_quiet;
        busy |-> dev_sda_oe_n;
    endproperty
    property p_busy_at_stop;
        $rose(busy) |-> scl && sda;
    endproperty
    property p_busy_len;
        $fell(busy) |-> busy_cnt_r + 1 >= PROG_CYCLES && busy_cnt_r <= PROG_CYCLES + 1;
    endproperty
    property p_start_released;
        s_start |-> dev_sda_oe_n;
    endproperty
    property p_stop_quiet;
        s_stop |=> s_quiet8;
    endproperty
    property p_drive_bound;
        $fell(dev_sda_oe_n) |-> ##[1:600] dev_sda_oe_n;
    endproperty
    property p_od_low;
        !dev_sda_oe_n |-> !dev_sda_o && !sda;
    endproperty

    a_dev_stable_high: assert property (p_dev_stable_high)
        else $error("client data changed while clock high");
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("client drove data line while programming");
    a_busy_at_stop: assert property (p_busy_at_stop)
        else $error("programming started outside a stop");
    a_busy_len: assert property (p_busy_len)
        else $error("programming interval has wrong length");
    a_start_released: assert property (p_start_released)
        else $error("client drove data line at a start");
    a_stop_quiet: assert property (p_stop_quiet)
        else $error("client drove data line after a stop");
    a_drive_bound: assert property (p_drive_bound)
        else $error("client held data line low too long");
    a_od_low: assert property (p_od_low)
        else $error("client enable did not pull line low");
endmodule : ecr_chk

// ### sim/tb_eeprom_client_read_and_ack_poll.sv
// self-checking bench: host and memory client joined on one bus
module tb_eeprom_client_read_and_ack_poll;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned PROG = 400;
    localparam int unsigned QTR = 4;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    ecr_pkg::ecr_op_t cmd_op = ecr_pkg::ECR_OP_WRITE;
    logic [9:0] cmd_addr = 10'h000;
    logic [7:0] cmd_wdata = 8'h00;
    logic [7:0] cmd_rd_len = 8'h00;
    logic rd_valid, done, done_nack, busy;
    logic [7:0] rd_data;
    logic [9:0] pointer;
    logic [9:0] wire_sh = 10'h000;
    logic [7:0] mem_m [1024];
    logic [7:0] rdq [$];
    logic [9:0] wr_a [$] = {10'h0ff, 10'h100, 10'h3fe, 10'h3ff, 10'h000};
    int failures = 0;
    int n_checks = 0;

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

    ecr_if bus_if ();
    ecr_client #(.PROG_CYCLES(PROG)) u_ecr_client (.core_clk(core_clk), .rst(rst),
        .bus(bus_if.dev), .busy(busy), .pointer(pointer));
    ecr_host #(.QTR_CYCLES(QTR)) u_ecr_host (.core_clk(core_clk), .rst(rst),
        .bus(bus_if.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_rd_len(cmd_rd_len),
        .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .done_nack(done_nack));
    ecr_chk #(.PROG_CYCLES(PROG)) u_ecr_chk (.core_clk(core_clk), .rst(rst),
        .scl(bus_if.scl), .sda(bus_if.sda), .dev_sda_o(bus_if.dev_sda_o),
        .dev_sda_oe_n(bus_if.dev_sda_oe_n), .busy(busy));

    always #2 core_clk = ~core_clk;
    // line level at every clock rise, last ten kept
    always @(posedge bus_if.scl) wire_sh <= {wire_sh[8:0], bus_if.sda};

    function automatic logic [9:0] next_addr(input logic [9:0] a);
        return a + 10'h001;
    endfunction : next_addr

    task automatic test_done;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    task automatic run_cmd(input ecr_pkg::ecr_op_t op, input logic [9:0] a,
                           input logic [7:0] wd, input logic [7:0] len);
        int k;
        rdq.delete();
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = wd;
        cmd_rd_len = len;
        cmd_valid = 1'b1;
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b0;
        `CHK("ready in frame", 1'b0, cmd_ready)
        for (k = 0; k < 4000; k++) begin
            @(posedge core_clk);
            #1;
            if (rd_valid === 1'b1) rdq.push_back(rd_data);
            if (done === 1'b1) break;
        end
        `CHK("done seen", 1'b1, done)
        `CHK("ready after done", 1'b1, cmd_ready)
        `CHK("idle clock", 1'b1, bus_if.scl)
        `CHK("idle data", 1'b1, bus_if.sda)
    endtask : run_cmd

    task automatic wait_ready;
        int n;
        n = 0;
        while (done_nack === 1'b1 && n < 20) begin
            run_cmd(ecr_pkg::ECR_OP_POLL, 10'h000, 8'h00, 8'h00);
            n++;
        end
        `CHK("poll acked", 1'b0, done_nack)
        `CHK("busy after ack", 1'b0, busy)
    endtask : wait_ready

    task automatic write_poll(input logic [9:0] a, input logic [7:0] d);
        run_cmd(ecr_pkg::ECR_OP_WRITE, a, d, 8'h00);
        mem_m[a] = d;
        `CHK("write acked", 1'b0, done_nack)
        `CHK("pointer after write", next_addr(a), pointer)
        run_cmd(ecr_pkg::ECR_OP_POLL, 10'h000, 8'h00, 8'h00);
        `CHK("poll while busy", 1'b1, done_nack)
        wait_ready();
    endtask : write_poll

    task automatic check_rd(input logic [9:0] a, input int len);
        logic [9:0] p;
        p = a;
        `CHK("read count", len, rdq.size())
        foreach (rdq[i]) begin
            `CHK("read byte", mem_m[p], rdq[i])
            p = next_addr(p);
        end
        `CHK("pointer after read", p, pointer)
    endtask : check_rd

    initial begin
        #240000;
        $display("wrong value watchdog expected done seen hang");
        failures++;
        test_done();
    end

    initial begin
        void'($urandom(73480));
        repeat (4) wr_a.push_back(10'($urandom()));
        repeat (16) @(posedge core_clk);
        #1;
        rst = 1'b0;
        `CHK("reset pointer", 10'h000, pointer)
        foreach (wr_a[i]) write_poll(wr_a[i], 8'($urandom()));
        $display("test write and poll finished");
        foreach (wr_a[i]) begin
            run_cmd(ecr_pkg::ECR_OP_RAND, wr_a[i], 8'h00, 8'h01);
            check_rd(wr_a[i], 1);
            `CHK("wire bits", {mem_m[wr_a[i]], 2'h2}, wire_sh)
        end
        $display("test random read finished");
        run_cmd(ecr_pkg::ECR_OP_RAND, 10'h0ff, 8'h00, 8'h01);
        run_cmd(ecr_pkg::ECR_OP_CUR, 10'($urandom()), 8'h00, 8'h01);
        check_rd(10'h100, 1);
        run_cmd(ecr_pkg::ECR_OP_RAND, 10'h3ff, 8'h00, 8'h01);
        // a length of zero still reads one byte
        run_cmd(ecr_pkg::ECR_OP_CUR, 10'($urandom()), 8'h00, 8'h00);
        check_rd(10'h000, 1);
        $display("test current read finished");
        run_cmd(ecr_pkg::ECR_OP_RAND, 10'h3fe, 8'h00, 8'h03);
        check_rd(10'h3fe, 3);
        $display("test sequential read finished");
        run_cmd(ecr_pkg::ECR_OP_WRITE, 10'h0ff, 8'h5a, 8'h00);
        mem_m[10'h0ff] = 8'h5a;
        run_cmd(ecr_pkg::ECR_OP_RAND, 10'h3fe, 8'h00, 8'h01);
        `CHK("busy read refused", 1'b1, done_nack)
        `CHK("busy read bytes", 0, rdq.size())
        `CHK("busy pointer kept", 10'h100, pointer)
        wait_ready();
        run_cmd(ecr_pkg::ECR_OP_RAND, 10'h0ff, 8'h00, 8'h02);
        check_rd(10'h0ff, 2);
        $display("test busy refusal finished");
        test_done();
    end
endmodule : tb_eeprom_client_read_and_ack_poll
